// ### hdl/sesp_slot_policy.sv
// configuration zone policy: slot locks, extra bytes, counters, key use checks
// assumes a decoded command strobe from the bus front end on the same clock
`timescale 1ns/1ps
`include "sesp_regs.svh"
// What this block does
// - unique serial number held in config bytes 0-3 and 8-12
// - answer the bus at 7-bit address 0x36 unless overridden
// - watchdog returns device to idle after at most 1.3 s active
// - io protection enabled, key taken from slot 6
// - only slots 2-6, 8, 10-12, 13, 15 may be lockable; 10-12 alike
// - a lockable slot accepts single-slot lock once, never unlocks
// - 16-bit lock flags at bytes 88-89, all ones, zero when locked
// - all direct writes to the config zone are rejected
// - non-zero byte 85 replaces default address, written by extra update
// - address byte may be rewritten only once
// - new address applies only when the device next goes idle, by sleep or watchdog timeout; reset restores the default
// - user byte at 84, updated once by extra update
// - two counters from zero to 2097151, counter command only
// - health failure flag cleared after the failing command
// - slot policy derived from two slot and two key config bytes
// - private key slots never returned by a read
// - secondary keys replaced by mode 0x04 unless slot locked
// - slot 1 signs internal messages only
// - validated public key unusable until validated, fixed until invalidated
// - boot check runs in stored digest mode
// - mode 0x00 key generation computes slot 0 public key
// - device cert slot 10, signer key 11, signer cert 12
module sesp_slot_policy
   import sesp_pkg::*;
#(
   parameter logic [15:0] LOCKABLE   = `SESP_LOCKABLE_MASK, // factory lockable set
   parameter logic [71:0] SERIAL     = 72'ha5c3_0000_e700_0000_00, // arbitrary value
   parameter int unsigned WDT_CYCLES = `SESP_WDT_MS * `SESP_CLK_MHZ * 1000
)(
   input  wire logic       ref_clk,     // block clock
   input  wire logic       rst_n,       // async reset, active low
   input  wire logic       cmdValid,    // command strobe, one cycle
   input  wire sesp_cmd_t  cmdOp,       // command opcode
   input  wire logic [7:0] cmdMode,     // mode parameter
   input  wire logic [6:0] cmdAddr,     // config byte address or slot in low nibble
   input  wire logic [7:0] cmdData,     // write data byte
   input  wire logic       cmdInternal, // message came from internal generator
   input  wire logic       cmdZoneCfg,  // read/write targets the config zone
   input  wire logic       healthFail,  // random source health test failed, pulse
   output logic            rspValid,    // answer strobe, one cycle
   output logic [7:0]      rspStatus,   // answer status code
   output logic [7:0]      rspData,     // answer data byte
   output logic [6:0]      busAddr,     // address the bus interface answers on
   output logic [3:0]      ioProtSlot,  // slot holding the io protection key
   output logic            bootStored,  // boot check in stored digest mode
   output logic            genPubKey,   // pulse: compute slot 0 public key
   output logic            genReplace,  // pulse: replace key in slot
   output logic            healthFlag,  // health failure flag
   output logic            sleeping     // device idle
);
   initial begin
      if ((LOCKABLE[12:10] != 3'b000) && (LOCKABLE[12:10] != 3'b111))
         $error("slots 10 to 12 must share one lockable setting");
      if ((LOCKABLE & ~`SESP_LOCKABLE_MASK) != 16'h0000)
         $error("lockable set holds a slot that may not be lockable");
   end

   logic [7:0]  userByte;
   logic [7:0]  addrByte;
   logic        userUsed;
   logic        addrUsed;
   logic [15:0] lockFlags;
   logic [20:0] counter [2];
   logic [15:0] validated;
   sesp_state_t state;
   sesp_state_t next_state;
   logic        wdtExpire;
   logic [3:0]  slot;
   logic [7:0]  next_status;
   logic [7:0]  next_data;

   assign slot = cmdAddr[3:0];

   // kind of key in each slot, from the fixed slot and key config bytes
   function automatic sesp_kind_t slotKind(input logic [3:0] s);
      case (s)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4: slotKind = KT_PRIV;
         `SESP_VALPUB_SLOT:            slotKind = KT_PUBVAL;
         `SESP_DEVCERT_SLOT, `SESP_SIGNCERT_SLOT: slotKind = KT_DATA;
         4'hd, `SESP_BOOTPUB_SLOT, `SESP_SIGNPUB_SLOT: slotKind = KT_PUB;
         default:                      slotKind = KT_DATA;
      endcase
   endfunction

   // secondary keys are the replaceable private keys
   function automatic logic isSecondary(input logic [3:0] s);
      isSecondary = (s == 4'h2) || (s == 4'h3) || (s == 4'h4);
   endfunction

   // serial, extra-byte and lock config bytes read back; others read zero
   function automatic logic [7:0] cfgByte(input logic [6:0] a, input logic [71:0] sn,
                                          input logic [7:0] ub, input logic [7:0] ab,
                                          input logic [15:0] lf);
      if (a <= `SESP_OFF_SN3)
         cfgByte = sn[71 - 8*a[1:0] -: 8];
      else if (a >= `SESP_OFF_SN8 && a <= `SESP_OFF_SN12)
         cfgByte = sn[39 - 8*(a[2:0] + 3'h0) -: 8];
      else if (a == `SESP_OFF_USER)
         cfgByte = ub;
      else if (a == `SESP_OFF_ADDR)
         cfgByte = ab;
      else if (a == `SESP_OFF_LOCK_LO)
         cfgByte = lf[7:0];
      else if (a == `SESP_OFF_LOCK_HI)
         cfgByte = lf[15:8];
      else
         cfgByte = 8'h00;
   endfunction

   assign ioProtSlot = `SESP_IOPROT_SLOT;
   assign bootStored = 1'b1;

   sesp_watchdog #(
      .LIMIT (WDT_CYCLES)
   ) u_wdt (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .run     (state != ST_IDLE),
      .expire  (wdtExpire)
   );

   // activity state: wake on any command but sleep, back to idle on sleep or timeout
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:   if (cmdValid && cmdOp != CMD_SLEEP) next_state = ST_ACTIVE;
         ST_ACTIVE: begin
            if (wdtExpire) next_state = ST_IDLE;
            else if (cmdValid && cmdOp == CMD_SLEEP) next_state = ST_DONE;
         end
         ST_DONE:   next_state = ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) state <= ST_IDLE;
      else        state <= next_state;
   end
   assign sleeping = (state == ST_IDLE);

   // address takes effect only on entry to sleep, not on write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busAddr <= `SESP_DEFAULT_ADDR;
      end else if (state != ST_IDLE && next_state == ST_IDLE) begin
         busAddr <= (addrByte != 8'h00) ? addrByte[6:0] : `SESP_DEFAULT_ADDR;
      end
   end

   // command decode: status and data for the answer
   always_comb begin
      next_status = `SESP_ST_OK;
      next_data   = 8'h00;
      case (cmdOp)
         CMD_READ: begin
            if (cmdZoneCfg)
               next_data = cfgByte(cmdAddr, SERIAL, userByte, addrByte, lockFlags);
            else if (slotKind(slot) == KT_PRIV || slot == `SESP_IOPROT_SLOT)
               next_status = `SESP_ST_REFUSED;
            else
               next_data = {4'h0, slot};
         end
         CMD_WRITE: begin
            if (cmdZoneCfg || !lockFlags[slot] || slotKind(slot) == KT_PRIV)
               next_status = `SESP_ST_REFUSED;
            else if (slotKind(slot) == KT_PUBVAL && validated[slot])
               next_status = `SESP_ST_REFUSED;
         end
         CMD_EXTRA: begin
            if (cmdMode[0] ? addrUsed : userUsed)
               next_status = `SESP_ST_REFUSED;
         end
         CMD_LOCK: begin
            if (!LOCKABLE[slot] || !lockFlags[slot])
               next_status = `SESP_ST_REFUSED;
         end
         CMD_KEY_GENERATE_CMD: begin
            if (cmdMode == `SESP_GEN_REPLACE) begin
               if (!isSecondary(slot) || !lockFlags[slot])
                  next_status = `SESP_ST_REFUSED;
            end else if (cmdMode != `SESP_GEN_PUBONLY || slot != `SESP_PRIMARY_SLOT) begin
               next_status = `SESP_ST_REFUSED;
            end
         end
         CMD_SIGN: begin
            if (slotKind(slot) != KT_PRIV)
               next_status = `SESP_ST_REFUSED;
            else if (slot == `SESP_ATTEST_SLOT && !cmdInternal)
               next_status = `SESP_ST_REFUSED;
         end
         CMD_VERIFY: begin
            if (slotKind(slot) == KT_PUBVAL && !cmdMode[1] && !validated[slot])
               next_status = `SESP_ST_REFUSED;
         end
         CMD_COUNTER: begin
            if (cmdMode[0] && counter[cmdAddr[0]] == `SESP_CNT_MAX)
               next_status = `SESP_ST_REFUSED;
            next_data = cmdAddr[1] ? {3'h0, counter[cmdAddr[0]][20:16]}
                      : (cmdAddr[2] ? counter[cmdAddr[0]][15:8] : counter[cmdAddr[0]][7:0]);
         end
         CMD_SLEEP: next_status = `SESP_ST_OK;
         default:   next_status = `SESP_ST_REFUSED;
      endcase
      if (healthFail) next_status = `SESP_ST_HEALTH;
   end

   // answer registers, one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rspValid  <= 1'b0;
         rspStatus <= `SESP_ST_OK;
         rspData   <= 8'h00;
      end else begin
         rspValid  <= cmdValid;
         rspStatus <= cmdValid ? next_status : rspStatus;
         rspData   <= cmdValid ? next_data : rspData;
      end
   end

   // once-writable extra bytes; factory contents are blank
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         userByte <= 8'h00;
         addrByte <= 8'h00;
         userUsed <= 1'b0;
         addrUsed <= 1'b0;
      end else if (cmdValid && cmdOp == CMD_EXTRA && next_status == `SESP_ST_OK) begin
         if (cmdMode[0]) begin
            addrByte <= cmdData;
            addrUsed <= 1'b1;
         end else begin
            userByte <= cmdData;
            userUsed <= 1'b1;
         end
      end
   end

   // lock flags only ever go from one to zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lockFlags <= `SESP_LOCK_RESET;
      end else if (cmdValid && cmdOp == CMD_LOCK && next_status == `SESP_ST_OK) begin
         lockFlags[slot] <= 1'b0;
      end
   end

   // monotonic counters saturate at the top rather than wrap
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cnt
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               counter[i] <= 21'h0;
            end else if (cmdValid && cmdOp == CMD_COUNTER && cmdMode[0] &&
                         cmdAddr[0] == 1'(i) && next_status == `SESP_ST_OK) begin
               counter[i] <= counter[i] + 21'h1;
            end
         end
      end
   endgenerate

   // validation state of validated-type public keys
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         validated <= 16'h0000;
      end else if (cmdValid && cmdOp == CMD_VERIFY && cmdMode[1] &&
                   slotKind(slot) == KT_PUBVAL && !healthFail) begin
         validated[slot] <= ~cmdMode[0];
      end
   end

   // key generation pulses toward the ecc engine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         genPubKey  <= 1'b0;
         genReplace <= 1'b0;
      end else begin
         genPubKey  <= cmdValid && cmdOp == CMD_KEY_GENERATE_CMD && cmdMode == `SESP_GEN_PUBONLY &&
                       next_status == `SESP_ST_OK;
         genReplace <= cmdValid && cmdOp == CMD_KEY_GENERATE_CMD && cmdMode == `SESP_GEN_REPLACE &&
                       next_status == `SESP_ST_OK;
      end
   end

   // flag shows a failure only during the failing answer, then clears
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) healthFlag <= 1'b0;
      else        healthFlag <= cmdValid && healthFail;
   end
endmodule

// ### hdl/sesp_regs.svh
// constants for the slot policy block: offsets, fields, reset values, timing
// assumes inclusion by the package and by every design file that needs a figure
`ifndef SESP_REGS_SVH
`define SESP_REGS_SVH
`define SESP_OFF_USER        7'h54
`define SESP_OFF_ADDR        7'h55
`define SESP_OFF_LOCK_LO     7'h58
`define SESP_OFF_LOCK_HI     7'h59
`define SESP_OFF_SN0         7'h00
`define SESP_OFF_SN3         7'h03
`define SESP_OFF_SN8         7'h08
`define SESP_OFF_SN12        7'h0c
`define SESP_DEFAULT_ADDR    7'h36
`define SESP_LOCK_RESET      16'hffff
`define SESP_LOCKABLE_MASK   16'hbd7c
`define SESP_CNT_MAX         21'h1fffff
`define SESP_WDT_MS          1300
`define SESP_CLK_MHZ         250
`define SESP_IOPROT_SLOT     4'h6
`define SESP_ATTEST_SLOT     4'h1
`define SESP_PRIMARY_SLOT    4'h0
`define SESP_DEVCERT_SLOT    4'ha
`define SESP_SIGNPUB_SLOT    4'hb
`define SESP_SIGNCERT_SLOT   4'hc
`define SESP_BOOTDIG_SLOT    4'h7
`define SESP_BOOTPUB_SLOT    4'hf
`define SESP_VALPUB_SLOT     4'he
`define SESP_GEN_PUBONLY     8'h00
`define SESP_GEN_REPLACE     8'h04
`define SESP_ST_OK           8'h00
`define SESP_ST_REFUSED      8'h01
`define SESP_ST_HEALTH       8'h07
`endif

// ### hdl/sesp_pkg.sv
// types shared by the slot policy block
// assumes the constants header is on the include path
`include "sesp_regs.svh"
package sesp_pkg;
   typedef enum logic [3:0] {
      CMD_NONE    = 4'h0,
      CMD_READ    = 4'h1,
      CMD_WRITE   = 4'h2,
      CMD_EXTRA   = 4'h3,
      CMD_LOCK    = 4'h4,
      CMD_KEY_GENERATE_CMD  = 4'h5,
      CMD_SIGN    = 4'h6,
      CMD_VERIFY  = 4'h7,
      CMD_COUNTER = 4'h8,
      CMD_SLEEP   = 4'h9
   } sesp_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_DONE   = 2'b11
   } sesp_state_t;
   typedef enum logic [1:0] {
      KT_DATA = 2'b00, KT_PRIV = 2'b01, KT_PUBVAL = 2'b10, KT_PUB = 2'b11
   } sesp_kind_t;
endpackage

// ### hdl/sesp_watchdog.sv
// active-time watchdog for the slot policy block
// assumes one clock; idle restarts the count, expire is a one-cycle pulse
`timescale 1ns/1ps
`include "sesp_regs.svh"
module sesp_watchdog
   import sesp_pkg::*;
#(
   parameter int unsigned LIMIT = `SESP_WDT_MS * `SESP_CLK_MHZ * 1000
)(
   input  wire logic ref_clk, // block clock
   input  wire logic rst_n,   // async reset, active low
   input  wire logic run,     // device is active
   output logic      expire   // one-cycle timeout pulse
);
   initial begin
      if (LIMIT < 2) $error("watchdog limit too small");
   end
   logic [31:0] count;
   // counts active cycles; idle clears it so each wake starts afresh
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count  <= 32'h0;
         expire <= 1'b0;
      end else if (!run) begin
         count  <= 32'h0;
         expire <= 1'b0;
      end else if (count == 32'(LIMIT - 1)) begin
         count  <= 32'h0;
         expire <= 1'b1;
      end else begin
         count  <= count + 32'h1;
         expire <= 1'b0;
      end
   end
endmodule

// ### dv/sesp_slot_policy_properties.sv
// concurrent checks on the ports of the slot policy block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
module sesp_slot_policy_checker
   import sesp_pkg::*;
#(
   parameter int unsigned WDT_CYCLES = 325000000 // watchdog limit in cycles
)(
   input wire logic       ref_clk,     // block clock
   input wire logic       rst_n,       // async reset, active low
   input wire logic       cmdValid,    // command strobe
   input wire sesp_cmd_t  cmdOp,       // opcode
   input wire logic [7:0] cmdMode,     // mode
   input wire logic [6:0] cmdAddr,     // byte address or slot
   input wire logic       cmdInternal, // internal message
   input wire logic       cmdZoneCfg,  // config zone target
   input wire logic       healthFail,  // health test failed
   input wire logic       rspValid,    // answer strobe
   input wire logic [7:0] rspStatus,   // answer status
   input wire logic [7:0] rspData,     // answer data
   input wire logic [6:0] busAddr,     // live bus address
   input wire logic [3:0] ioProtSlot,  // io protection slot
   input wire logic       bootStored,  // boot check mode
   input wire logic       genPubKey,   // public key pulse
   input wire logic       genReplace,  // key replace pulse
   input wire logic       healthFlag,  // health flag
   input wire logic       sleeping     // device idle
);
   int unsigned awake; // awake cycles since the last command
   // restart on commands too; the watchdog itself restarts only when the device goes idle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) awake <= 0;
      else if (sleeping || cmdValid) awake <= 0;
      else awake <= awake + 1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_answer_follows: assert property (cmdValid |=> rspValid)
      else $error("no answer one cycle after a command");
   a_no_stray: assert property (!cmdValid |=> !rspValid)
      else $error("answer without a command");
   a_status_holds: assert property (!rspValid |->
      $stable(rspStatus) && $stable(rspData))
      else $error("answer fields moved between answers");
   a_io_slot: assert property (ioProtSlot == 4'h6)
      else $error("io protection slot wrong");
   a_boot_mode: assert property (bootStored)
      else $error("boot check not in stored digest mode");
   a_health_answer: assert property (cmdValid && healthFail |=>
      rspStatus == 8'h07 && healthFlag && !genReplace)
      else $error("health failure not answered with 07");
   a_health_cause: assert property (healthFlag |-> $past(cmdValid && healthFail))
      else $error("health flag without a failing command");
   a_cfg_write: assert property (cmdValid && cmdOp == CMD_WRITE && cmdZoneCfg &&
      !healthFail |=> rspStatus == 8'h01)
      else $error("config write not refused");
   a_priv_read: assert property (cmdValid && cmdOp == CMD_READ && !cmdZoneCfg &&
      cmdAddr[3:0] < 4'h5 && !healthFail |=> rspStatus == 8'h01)
      else $error("private slot read not refused");
   a_sign_ext: assert property (cmdValid && cmdOp == CMD_SIGN &&
      cmdAddr[3:0] == 4'h1 && !cmdInternal && !healthFail |=> rspStatus == 8'h01)
      else $error("external sign with slot 1 not refused");
   a_pub_gen: assert property (cmdValid && cmdOp == CMD_KEY_GENERATE_CMD && cmdMode == 8'h00 &&
      cmdAddr[3:0] == 4'h0 && !healthFail |=> genPubKey && rspStatus == 8'h00)
      else $error("mode 00 key generation gave no public key");
   a_replace_cause: assert property (genReplace |->
      $past(cmdValid && cmdOp == CMD_KEY_GENERATE_CMD && cmdMode == 8'h04))
      else $error("key replaced without mode 04");
   a_addr_at_idle: assert property ($changed(busAddr) |-> sleeping)
      else $error("bus address changed while active");
   a_watchdog: assert property (!sleeping |-> awake <= WDT_CYCLES + 4)
      else $error("device active past the watchdog limit");
   c_lock_ok: cover property (cmdValid && cmdOp == CMD_LOCK ##1 rspStatus == 8'h00);
   c_health: cover property (healthFlag);
   c_replace: cover property (genReplace);
   c_new_addr: cover property ($changed(busAddr));
endmodule
bind sesp_slot_policy sesp_slot_policy_checker #(.WDT_CYCLES(WDT_CYCLES)) i_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdMode(cmdMode),
   .cmdAddr(cmdAddr), .cmdInternal(cmdInternal), .cmdZoneCfg(cmdZoneCfg),
   .healthFail(healthFail), .rspValid(rspValid), .rspStatus(rspStatus), .rspData(rspData),
   .busAddr(busAddr), .ioProtSlot(ioProtSlot), .bootStored(bootStored),
   .genPubKey(genPubKey), .genReplace(genReplace), .healthFlag(healthFlag),
   .sleeping(sleeping));

// ### dv/sesp_host_model.sv
// host model: drives one command per call, back to back when called each cycle
// assumes its tasks are entered just after a falling clock edge
`timescale 1ns/1ps
module sesp_host_model
   import sesp_pkg::*;
(
   output logic       cmdValid,    // command strobe
   output sesp_cmd_t  cmdOp,       // opcode
   output logic [7:0] cmdMode,     // mode
   output logic [6:0] cmdAddr,     // byte address or slot
   output logic [7:0] cmdData,     // data byte
   output logic       cmdInternal, // internal message
   output logic       cmdZoneCfg,  // config zone target
   output logic       healthFail   // health test failed
);
   // quiet bus at time zero
   initial begin
      cmdValid = 1'b0;
      cmdOp = CMD_NONE;
      {cmdMode, cmdAddr, cmdData, cmdInternal, cmdZoneCfg, healthFail} = '0;
   end
   task automatic send(input sesp_cmd_t op, input logic [7:0] mode, input logic [6:0] addr,
                       input logic [7:0] data, input logic [2:0] flg);
      cmdValid = 1'b1;
      cmdOp = op;
      cmdMode = mode;
      cmdAddr = addr;
      cmdData = data;
      {cmdInternal, cmdZoneCfg, healthFail} = flg;
   endtask
   // released mode, address and data fields flip so a stale value is never mistaken for a live one
   task automatic drop();
      cmdValid = 1'b0;
      {cmdMode, cmdAddr, cmdData} = ~{cmdMode, cmdAddr, cmdData};
   endtask
   // a host wanting no change still writes the default address
   function automatic logic [7:0] pick_address(input logic [6:0] want);
      return (want == 7'h00) ? 8'h36 : {1'b0, want};
   endfunction
endmodule

// ### dv/test_secure_element_slot_policy.sv
// self-checking bench: host model in front, model state kept in integers
// assumes the design answers one cycle after each command
`timescale 1ns/1ps
`include "sesp_regs.svh"
module test_secure_element_slot_policy
   import sesp_pkg::*;
;
   localparam int WDT = 200; // short watchdog keeps the run brief
   logic        ref_clk, rst_n, cmdValid, cmdInternal, cmdZoneCfg, healthFail;
   sesp_cmd_t   cmdOp;
   logic [7:0]  cmdMode, cmdData, rspStatus, rspData;
   logic [6:0]  cmdAddr, busAddr;
   logic [3:0]  ioProtSlot;
   logic        rspValid, bootStored, genPubKey, genReplace, healthFlag, sleeping;
   logic [31:0] lfsr = 32'h57f8f6a5;
   int          failures = 0, n_checks = 0, lockF = 16'hffff, userB, addrB, st;
   int          cnt[2] = '{0, 0};
   int          order[$];
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   sesp_host_model i_host (.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdMode(cmdMode),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdInternal(cmdInternal),
      .cmdZoneCfg(cmdZoneCfg), .healthFail(healthFail));
   sesp_slot_policy #(.WDT_CYCLES(WDT)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdMode(cmdMode), .cmdAddr(cmdAddr),
      .cmdData(cmdData), .cmdInternal(cmdInternal), .cmdZoneCfg(cmdZoneCfg),
      .healthFail(healthFail), .rspValid(rspValid), .rspStatus(rspStatus), .rspData(rspData),
      .busAddr(busAddr), .ioProtSlot(ioProtSlot), .bootStored(bootStored),
      .genPubKey(genPubKey), .genReplace(genReplace), .healthFlag(healthFlag),
      .sleeping(sleeping));
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one command; its answer is looked at in the cycle it stands
   task automatic cmd(input sesp_cmd_t op, input logic [7:0] mode, input logic [6:0] addr,
                      input logic [7:0] data, input logic [2:0] flg, input int expSt,
                      input int expD);
      i_host.send(op, mode, addr, data, flg);
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("rspValid", 8'h01, {7'h00, rspValid});
      check("rspStatus", expSt[7:0], rspStatus);
      if (expD >= 0) check("rspData", expD[7:0], rspData);
   endtask
   task automatic rd(input logic [6:0] a, input int d);
      cmd(CMD_READ, 8'h00, a, 8'h00, 3'b010, 0, d);
   endtask
   task automatic wait_idle(input int lim);
      int n;
      i_host.drop();
      for (n = 0; n < lim && sleeping !== 1'b1; n++) @(negedge ref_clk);
      if (n == lim) begin
         failures++;
         $display("CHECK FAILED sleeping expected 1 seen %b", sleeping);
         stop_test();
      end
   endtask
   initial begin
      rst_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      rd(7'h58, 8'hff);
      rd(7'h59, 8'hff);
      check("busAddr", 8'h36, {1'b0, busAddr});
      // key replacement on slots 0 to 5, then on a freshly locked slot
      for (int s = 0; s < 6; s++) begin
         st = (s >= 2 && s <= 4) ? 0 : 1;
         cmd(CMD_KEY_GENERATE_CMD, 8'h04, 7'(s), 8'h00, 3'b000, st, -1);
         check("genReplace", 8'(1 - st), {7'h00, genReplace});
      end
      cmd(CMD_LOCK, 8'h00, 7'h03, 8'h00, 3'b000, 0, -1);
      lockF[3] = 0;
      cmd(CMD_KEY_GENERATE_CMD, 8'h04, 7'h03, 8'h00, 3'b000, 1, -1);
      cmd(CMD_KEY_GENERATE_CMD, 8'h00, 7'h00, 8'h00, 3'b000, 0, -1);
      check("genPubKey", 8'h01, {7'h00, genPubKey});
      // every slot twice from a random start: second locks and unlockable slots fail
      lfsr = lfsr_step(lfsr);
      for (int i = 0; i < 32; i++) order.push_back((i + lfsr[3:0]) % 16);
      foreach (order[i]) begin
         st = ((`SESP_LOCKABLE_MASK & lockF & (1 << order[i])) != 0) ? 0 : 1;
         cmd(CMD_LOCK, 8'h00, 7'(order[i]), 8'h00, 3'b000, st, -1);
         if (st == 0) lockF[order[i]] = 0;
      end
      rd(7'h58, lockF & 8'hff);
      rd(7'h59, lockF >> 8);
      // health failure answers 07 and changes nothing; the retry succeeds once
      lfsr = lfsr_step(lfsr);
      userB = lfsr[15:8];
      cmd(CMD_EXTRA, 8'h00, 7'h54, 8'(userB), 3'b001, 7, -1);
      check("healthFlag", 8'h01, {7'h00, healthFlag});
      rd(7'h54, 8'h00);
      cmd(CMD_EXTRA, 8'h00, 7'h54, 8'(userB), 3'b000, 0, -1);
      check("healthFlag", 8'h00, {7'h00, healthFlag});
      cmd(CMD_EXTRA, 8'h00, 7'h54, 8'(~userB), 3'b000, 1, -1);
      rd(7'h54, userB);
      addrB = i_host.pick_address(lfsr[22:16] | 7'h10);
      cmd(CMD_EXTRA, 8'h01, 7'h55, 8'(addrB), 3'b000, 0, -1);
      check("busAddr", 8'h36, {1'b0, busAddr});
      cmd(CMD_EXTRA, 8'h01, 7'h55, 8'h36, 3'b000, 1, -1);
      cmd(CMD_WRITE, 8'h00, 7'h55, 8'h36, 3'b010, 1, -1);
      rd(7'h55, addrB);
      // data slots: secret slots unreadable, locked and private ones unwritable
      for (int s = 0; s < 16; s++) begin
         cmd(CMD_READ, 8'h00, 7'(s), 8'h00, 3'b000, (s < 5 || s == 6), -1);
         st = (s < 5 || !lockF[s]) ? 1 : 0;
         cmd(CMD_WRITE, 8'h00, 7'(s), lfsr[7:0], 3'b000, st, -1);
      end
      cmd(CMD_SIGN, 8'h00, 7'h01, 8'h00, 3'b000, 1, -1);
      cmd(CMD_SIGN, 8'h00, 7'h01, 8'h00, 3'b100, 0, -1);
      // validated key: use, validate, use, write, invalidate, write
      cmd(CMD_VERIFY, 8'h00, 7'h0e, 8'h00, 3'b000, 1, -1);
      cmd(CMD_VERIFY, 8'h02, 7'h0e, 8'h00, 3'b000, 0, -1);
      cmd(CMD_VERIFY, 8'h00, 7'h0e, 8'h00, 3'b000, 0, -1);
      cmd(CMD_WRITE, 8'h00, 7'h0e, 8'h5a, 3'b000, 1, -1);
      cmd(CMD_VERIFY, 8'h03, 7'h0e, 8'h00, 3'b000, 0, -1);
      cmd(CMD_WRITE, 8'h00, 7'h0e, 8'h5a, 3'b000, 0, -1);
      // counters step independently from zero
      for (int i = 0; i < 5 + lfsr[2:0]; i++) begin
         cmd(CMD_COUNTER, 8'h01, 7'(i & 1), 8'h00, 3'b000, 0, -1);
         cnt[i & 1]++;
      end
      for (int c = 0; c < 2; c++) begin
         cmd(CMD_COUNTER, 8'h00, 7'(c), 8'h00, 3'b000, 0, cnt[c]);
         cmd(CMD_COUNTER, 8'h00, 7'(c + 4), 8'h00, 3'b000, 0, cnt[c] >> 8);
         cmd(CMD_COUNTER, 8'h00, 7'(c + 2), 8'h00, 3'b000, 0, cnt[c] >> 16);
      end
      // new address applies once the device has gone idle
      cmd(CMD_SLEEP, 8'h00, 7'h00, 8'h00, 3'b000, 0, -1);
      wait_idle(20);
      repeat (2) @(negedge ref_clk);
      check("busAddr", 8'(addrB), {1'b0, busAddr});
      rd(7'h55, addrB);
      wait_idle(WDT + 20);
      stop_test();
   end
endmodule
